//--- core/arc_converter.sv
// Purpose: audio sample rate converter with density-modulated serial port
// Assumes: all inputs synchronous to clk_in; reads answer one cycle later
// Notes: conversion core is a zero-order hold between input and output ticks
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module arc_converter #(
	parameter int unsigned MEAS_WINDOW_CYCLES = arc_pkg::MEAS_WINDOW_CYC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [31:0] reg_rdata_out,
	// serial audio controller side
	input wire logic [arc_pkg::SAMP_W-1:0] serial_in_left_in,
	input wire logic [arc_pkg::SAMP_W-1:0] serial_in_right_in,
	input wire logic serial_audio_frame_sync_in,
	input wire logic serial_out_frame_sync_in,
	output logic [arc_pkg::SAMP_W-1:0] serial_out_left_out,
	output logic [arc_pkg::SAMP_W-1:0] serial_out_right_out,
	// density-modulated port
	output logic density_bit_clock_out,
	input wire logic density_data_in,
	output logic density_data_out,
	// sync interrupts
	output logic input_sample_irq_out,
	output logic output_sample_irq_out
);
	import arc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// keep a programmed rate inside the supported band
	function automatic logic [RATE_W-1:0] clamp_rate(input logic [31:0] v);
		if (v < 32'(RATE_MIN)) begin
			clamp_rate = RATE_MIN;
		end else if (v > 32'(RATE_MAX)) begin
			clamp_rate = RATE_MAX;
		end else begin
			clamp_rate = v[RATE_W-1:0];
		end
	endfunction : clamp_rate

	// ones count over 64 bits to a left aligned signed sample
	function automatic logic [SAMP_W-1:0] dens_to_sample(input logic [6:0] n);
		logic [7:0] d;
		d = {1'b0, n} - DENS_ZERO;
		dens_to_sample = {d[6:0], 17'h00000};
	endfunction : dens_to_sample

	////////////////////////////////////////////////////////////////////////
	// control registers

	logic in_auto;
	logic out_auto;
	logic dclk_run;
	logic lr_swap;
	arc_src_t route_src;
	logic dens_out_sel;
	logic ser_out_sel;
	logic [HALF_W-1:0] dclk_half;
	logic [RATE_W-1:0] in_rate_man;
	logic [RATE_W-1:0] out_rate_man;
	logic [SAMP_W-1:0] in_word_a;
	logic [SAMP_W-1:0] in_word_b;
	logic [SAMP_W-1:0] wd_hi;

	assign wd_hi = reg_wdata_in[31:8];

	// software writes steer mode, routing, rates and bit clock
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			in_auto <= 1'b0;
			out_auto <= 1'b0;
			dclk_run <= 1'b0;
			lr_swap <= 1'b0;
			route_src <= SRC_REG;
			dens_out_sel <= 1'b0;
			ser_out_sel <= 1'b0;
			dclk_half <= RST_DCLK_HALF;
			in_rate_man <= RST_RATE;
			out_rate_man <= RST_RATE;
		end else if (reg_write_in) begin
			case (reg_addr_in)
				OFS_CTRL: begin
					in_auto <= reg_wdata_in[CTRL_IN_AUTO];
					out_auto <= reg_wdata_in[CTRL_OUT_AUTO];
					dclk_run <= reg_wdata_in[CTRL_DCLK_RUN];
					lr_swap <= reg_wdata_in[CTRL_LR_SWAP];
				end
				OFS_ROUTE: begin
					route_src <= arc_src_t'(reg_wdata_in[ROUTE_SRC_LSB +: 2]);
					dens_out_sel <= reg_wdata_in[ROUTE_DENS_OUT];
					ser_out_sel <= reg_wdata_in[ROUTE_SER_OUT];
				end
				OFS_IN_RATE: in_rate_man <= clamp_rate(reg_wdata_in);
				OFS_OUT_RATE: out_rate_man <= clamp_rate(reg_wdata_in);
				OFS_DCLK_DIV: begin
					// clamp keeps the bit clock between 62.5 kHz and 4 MHz
					if (reg_wdata_in < 32'(DCLK_HALF_MIN_CYC)) begin
						dclk_half <= HALF_W'(DCLK_HALF_MIN_CYC);
					end else if (reg_wdata_in > 32'(DCLK_HALF_MAX_CYC)) begin
						dclk_half <= HALF_W'(DCLK_HALF_MAX_CYC);
					end else begin
						dclk_half <= reg_wdata_in[HALF_W-1:0];
					end
				end
				default: ;
			endcase
		end
	end

	// input words are single buffered: a second write overwrites the first
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			in_word_a <= '0;
			in_word_b <= '0;
		end else if (reg_write_in && reg_addr_in == OFS_IN_A) begin
			in_word_a <= wd_hi;
		end else if (reg_write_in && reg_addr_in == OFS_IN_B) begin
			in_word_b <= wd_hi;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// density bit clock

	logic [HALF_W-1:0] half_cnt;
	logic dclk;
	logic dclk_edge;
	logic fall_evt;
	logic rise_evt;

	assign dclk_edge = dclk_run && (half_cnt >= dclk_half - 9'h001);
	assign fall_evt = dclk_edge && dclk;
	assign rise_evt = dclk_edge && !dclk;
	assign density_bit_clock_out = dclk;

	// divided from the system clock; parked low while stopped for sleep
	always_ff @(posedge clk_in) begin
		if (reset_in || !dclk_run) begin
			half_cnt <= '0;
			dclk <= 1'b0;
		end else if (dclk_edge) begin
			half_cnt <= '0;
			dclk <= ~dclk;
		end else begin
			half_cnt <= half_cnt + 9'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// density input decimation

	logic [5:0] bit_cnt;
	logic [6:0] ones_l;
	logic [6:0] ones_r;
	logic [6:0] ones_r_next;
	logic dens_frame;
	logic [SAMP_W-1:0] dens_l;
	logic [SAMP_W-1:0] dens_r;

	assign ones_r_next = ones_r + {6'h00, density_data_in};

	// one sample per 64 bit clocks, so the measured rate is bit clock / 64
	always_ff @(posedge clk_in) begin
		if (reset_in || !dclk_run) begin
			bit_cnt <= '0;
			ones_l <= '0;
			ones_r <= '0;
			dens_frame <= 1'b0;
		end else begin
			dens_frame <= 1'b0;
			if (fall_evt) begin
				ones_l <= ones_l + {6'h00, density_data_in};
			end
			if (rise_evt) begin
				if (bit_cnt == DENS_LAST_BIT) begin
					bit_cnt <= '0;
					ones_l <= '0;
					ones_r <= '0;
					dens_frame <= 1'b1;
				end else begin
					bit_cnt <= bit_cnt + 6'h01;
					ones_r <= ones_r_next;
				end
			end
		end
	end

	// decimated samples, left aligned like the linear path
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			dens_l <= '0;
			dens_r <= '0;
		end else if (rise_evt && bit_cnt == DENS_LAST_BIT) begin
			dens_l <= dens_to_sample(ones_l);
			dens_r <= dens_to_sample(ones_r_next);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// rate ticks: side 0 is input, side 1 is output

	logic fs_in_q;
	logic fs_out_q;
	logic ser2ser;
	logic rate_odd;
	logic [1:0] auto_eff;
	logic [1:0] auto_tick;
	logic [1:0] tick;
	logic [RATE_W-1:0] rate_sel [2];
	logic [RATE_W-1:0] meas [2];

	// frame sync edge detection
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			fs_in_q <= 1'b0;
			fs_out_q <= 1'b0;
		end else begin
			fs_in_q <= serial_audio_frame_sync_in;
			fs_out_q <= serial_out_frame_sync_in;
		end
	end

	// a density path always runs its side from the bit clock
	assign auto_eff[0] = in_auto || (route_src == SRC_DENS);
	assign auto_eff[1] = out_auto || dens_out_sel;
	assign auto_tick[0] = (route_src == SRC_DENS) ? dens_frame :
		(serial_audio_frame_sync_in && !fs_in_q);
	assign auto_tick[1] = dens_out_sel ? dens_frame :
		(serial_out_frame_sync_in && !fs_out_q);

	// serial to serial resampling rounds the output rate down to 8 kHz steps
	assign ser2ser = (route_src == SRC_SERIAL) && ser_out_sel;
	assign rate_odd = (out_rate_man % RATE_STEP) != '0;
	assign rate_sel[0] = in_rate_man;
	assign rate_sel[1] = ser2ser ? out_rate_man - (out_rate_man % RATE_STEP)
		: out_rate_man;

	for (genvar s = 0; s < 2; s++) begin : g_side
		logic [ACC_W-1:0] acc;
		logic [ACC_W:0] acc_sum;
		logic man_tick;
		logic [31:0] win_cnt;
		logic [RATE_W-1:0] ev_cnt;
		logic [RATE_W-1:0] meas_r;

		assign acc_sum = {1'b0, acc} + {{(ACC_W + 1 - RATE_W){1'b0}}, rate_sel[s]};

		// phase accumulator: rate ticks per CLK_HZ cycles, no divider needed
		always_ff @(posedge clk_in) begin
			if (reset_in) begin
				acc <= '0;
				man_tick <= 1'b0;
			end else if (acc_sum >= (ACC_W + 1)'(CLK_HZ)) begin
				acc <= ACC_W'(acc_sum - (ACC_W + 1)'(CLK_HZ));
				man_tick <= 1'b1;
			end else begin
				acc <= acc_sum[ACC_W-1:0];
				man_tick <= 1'b0;
			end
		end

		assign tick[s] = auto_eff[s] ? auto_tick[s] : man_tick;

		// count sync events over a fixed window; the count is the rate in Hz
		always_ff @(posedge clk_in) begin
			if (reset_in) begin
				win_cnt <= '0;
				ev_cnt <= '0;
				meas_r <= '0;
			end else if (win_cnt == MEAS_WINDOW_CYCLES - 1) begin
				win_cnt <= '0;
				ev_cnt <= '0;
				meas_r <= ev_cnt + {{(RATE_W - 1){1'b0}}, auto_tick[s]};
			end else begin
				win_cnt <= win_cnt + 32'h00000001;
				ev_cnt <= ev_cnt + {{(RATE_W - 1){1'b0}}, auto_tick[s]};
			end
		end

		assign meas[s] = meas_r;
	end

	////////////////////////////////////////////////////////////////////////
	// conversion core and sync interrupts

	logic [SAMP_W-1:0] hold_a;
	logic [SAMP_W-1:0] hold_b;
	logic [SAMP_W-1:0] out_a;
	logic [SAMP_W-1:0] out_b;

	// input tick captures both channels from the selected source
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			hold_a <= '0;
			hold_b <= '0;
		end else if (tick[0]) begin
			unique case (route_src)
				SRC_SERIAL: begin
					hold_a <= serial_in_left_in;
					hold_b <= serial_in_right_in;
				end
				SRC_DENS: begin
					hold_a <= dens_l;
					hold_b <= dens_r;
				end
				SRC_REG: begin
					hold_a <= in_word_a;
					hold_b <= in_word_b;
				end
				default: begin
					hold_a <= in_word_a;
					hold_b <= in_word_b;
				end
			endcase
		end
	end

	// output tick presents the held pair to registers and serial port
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			out_a <= '0;
			out_b <= '0;
			serial_out_left_out <= '0;
			serial_out_right_out <= '0;
		end else if (tick[1]) begin
			out_a <= hold_a;
			out_b <= hold_b;
			serial_out_left_out <= ser_out_sel ? hold_a : '0;
			serial_out_right_out <= ser_out_sel ? hold_b : '0;
		end
	end

	// one-cycle pulses; edge inputs see one event and need no clearing
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			input_sample_irq_out <= 1'b0;
			output_sample_irq_out <= 1'b0;
		end else begin
			input_sample_irq_out <= tick[0];
			output_sample_irq_out <= tick[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// density output modulators, one per channel

	logic [1:0] dbit;
	logic slot_l;
	logic slot_r;

	for (genvar c = 0; c < 2; c++) begin : g_mod
		logic [25:0] err;
		logic [SAMP_W-1:0] x;

		assign x = (c == 0) ? out_a : out_b;

		// first order loop, one step per bit clock period
		always_ff @(posedge clk_in) begin
			if (reset_in) begin
				err <= '0;
				dbit[c] <= 1'b0;
			end else if (rise_evt) begin
				dbit[c] <= ~err[25];
				err <= err + {{2{x[SAMP_W-1]}}, x} -
					(err[25] ? 26'h3800000 : 26'h0800000);
			end
		end
	end

	// slot swap lets either device take either channel
	assign slot_l = lr_swap ? dbit[1] : dbit[0];
	assign slot_r = lr_swap ? dbit[0] : dbit[1];

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			density_data_out <= 1'b0;
		end else if (!dens_out_sel) begin
			density_data_out <= 1'b0;
		end else if (fall_evt) begin
			density_data_out <= slot_l;
		end else if (rise_evt) begin
			density_data_out <= slot_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register read port, data in the cycle after the strobe

	logic [31:0] ctrl_rd;

	always_comb begin
		ctrl_rd = '0;
		ctrl_rd[CTRL_IN_AUTO] = in_auto;
		ctrl_rd[CTRL_OUT_AUTO] = out_auto;
		ctrl_rd[CTRL_DCLK_RUN] = dclk_run;
		ctrl_rd[CTRL_LR_SWAP] = lr_swap;
		ctrl_rd[CTRL_RATE_ODD] = rate_odd;
	end

	// unmapped offsets and idle cycles read zero
	always_ff @(posedge clk_in) begin
		if (reset_in || !reg_read_in) begin
			reg_rdata_out <= '0;
		end else begin
			case (reg_addr_in)
				OFS_CTRL: reg_rdata_out <= ctrl_rd;
				OFS_ROUTE: reg_rdata_out <= {28'h0000000, ser_out_sel,
					dens_out_sel, route_src};
				OFS_IN_A: reg_rdata_out <= {in_word_a, 8'h00};
				OFS_IN_B: reg_rdata_out <= {in_word_b, 8'h00};
				OFS_OUT_A: reg_rdata_out <= {out_a, 8'h00};
				OFS_OUT_B: reg_rdata_out <= {out_b, 8'h00};
				OFS_IN_RATE: reg_rdata_out <= {14'h0000,
					auto_eff[0] ? meas[0] : in_rate_man};
				OFS_OUT_RATE: reg_rdata_out <= {14'h0000,
					auto_eff[1] ? meas[1] : out_rate_man};
				OFS_DCLK_DIV: reg_rdata_out <= {23'h000000, dclk_half};
				default: reg_rdata_out <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	sequence s_write_in_a;
		reg_write_in && reg_addr_in == OFS_IN_A;
	endsequence

	sequence s_read_out_a;
		reg_read_in && reg_addr_in == OFS_OUT_A;
	endsequence

	chk_word_align: assert property (
		s_write_in_a |=> in_word_a == $past(wd_hi))
		else $error("input word not taken from bits 31..8");

	chk_out_readback: assert property (
		s_read_out_a |=> reg_rdata_out == {$past(out_a), 8'h00})
		else $error("output word read back wrong");

	chk_irq_in_cause: assert property (
		tick[0] |=> input_sample_irq_out)
		else $error("input conversion without sync pulse");

	chk_irq_pulse: assert property (
		output_sample_irq_out |=> !output_sample_irq_out)
		else $error("output sync pulse longer than one cycle");

	chk_out_capture: assert property (
		tick[1] |=> out_a == $past(hold_a) && out_b == $past(hold_b))
		else $error("output tick did not take held samples");

	chk_sleep_low: assert property (
		!dclk_run |=> !density_bit_clock_out ##1 !dens_frame)
		else $error("bit clock active while stopped");

	chk_half_min: assert property (disable iff (reset_in || !dclk_run)
		$rose(dclk) |-> dclk[*5])
		else $error("bit clock high phase shorter than minimum");

	chk_dens_tick: assert property (
		route_src == SRC_DENS |=> input_sample_irq_out == $past(dens_frame))
		else $error("density input sync not paced by bit clock frame");

	chk_rate_range: assert property (
		in_rate_man >= RATE_MIN && in_rate_man <= RATE_MAX &&
		out_rate_man >= RATE_MIN && out_rate_man <= RATE_MAX)
		else $error("manual rate outside supported band");

	chk_left_fall: assert property (
		fall_evt |=> ones_l == $past(ones_l) + {6'h00, $past(density_data_in)})
		else $error("left bit not counted on falling edge");

	chk_slot_left: assert property (
		fall_evt && dens_out_sel |=> density_data_out == $past(slot_l))
		else $error("left slot bit not driven on falling edge");

endmodule : arc_converter

`default_nettype wire

//--- pkg/arc_pkg.sv
// Purpose: shared constants for the audio rate converter with density port
// Assumes: one 40 MHz system clock, synchronous active-high reset
// Notes: offsets are byte addresses on the plain register port
package arc_pkg;

	// clock and widths
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int RATE_W = 18;
	localparam int ACC_W = 26;
	localparam int SAMP_W = 24;
	localparam int HALF_W = 9;

	// register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ROUTE = 8'h04;
	localparam logic [7:0] OFS_IN_A = 8'h08;
	localparam logic [7:0] OFS_IN_B = 8'h0C;
	localparam logic [7:0] OFS_OUT_A = 8'h10;
	localparam logic [7:0] OFS_OUT_B = 8'h14;
	localparam logic [7:0] OFS_IN_RATE = 8'h18;
	localparam logic [7:0] OFS_OUT_RATE = 8'h1C;
	localparam logic [7:0] OFS_DCLK_DIV = 8'h20;

	// converter_control field positions
	localparam int CTRL_IN_AUTO = 0;
	localparam int CTRL_OUT_AUTO = 1;
	localparam int CTRL_DCLK_RUN = 2;
	localparam int CTRL_LR_SWAP = 3;
	localparam int CTRL_RATE_ODD = 8;

	// audio_route_select field positions
	localparam int ROUTE_SRC_LSB = 0;
	localparam int ROUTE_DENS_OUT = 2;
	localparam int ROUTE_SER_OUT = 3;

	// input source selection
	typedef enum logic [1:0] {
		SRC_REG = 2'b00,
		SRC_SERIAL = 2'b01,
		SRC_DENS = 2'b10
	} arc_src_t;

	// sample rate limits, also the 8 kHz resampling step
	localparam logic [RATE_W-1:0] RATE_MIN = 18'h01F40;
	localparam logic [RATE_W-1:0] RATE_MAX = 18'h2EE00;
	localparam logic [RATE_W-1:0] RATE_STEP = 18'h01F40;
	localparam logic [RATE_W-1:0] RST_RATE = 18'h0BB80;

	// density bit clock range and derived half-period counts
	localparam int unsigned DCLK_MIN_HZ = 62_500;
	localparam int unsigned DCLK_MAX_HZ = 4_000_000;
	localparam int unsigned DCLK_HALF_MIN_CYC = CLK_HZ / (2 * DCLK_MAX_HZ);
	localparam int unsigned DCLK_HALF_MAX_CYC = CLK_HZ / (2 * DCLK_MIN_HZ);
	localparam logic [HALF_W-1:0] RST_DCLK_HALF = 9'h014;

	// density decimation: bits per sample and zero level of the count
	localparam logic [5:0] DENS_LAST_BIT = 6'h3F;
	localparam logic [7:0] DENS_ZERO = 8'h20;

	// rate measurement window
	localparam int unsigned MEAS_WINDOW_MS = 1000;
	localparam int unsigned MEAS_WINDOW_CYC = CLK_HZ / 1000 * MEAS_WINDOW_MS;

endpackage : arc_pkg

//--- verif/arc_mic_model.sv
// Purpose: behavioural pair of density microphones on one shared data line
// Assumes: bit clock comes from the converter and is sampled on clk_in
// Notes: an idle bit clock puts the mics to sleep and releases the line
`timescale 1ns/100ps
`default_nettype none
module arc_mic_model (
	// clocks
	input wire logic clk_in,
	input wire logic bit_clk_in,
	// bit levels of the two microphones
	input wire logic left_in,
	input wire logic right_in,
	// shared data line
	output logic data_out
);
	logic bclk_d = 1'b0;
	logic line = 1'b0;
	logic [9:0] idle = 10'h000;
	assign data_out = line;
	////////////////////////////////////////////////////////////////////////
	// left mic drives after a rise, right mic after a fall
	always @(posedge clk_in) begin
		bclk_d <= bit_clk_in;
		if (bit_clk_in != bclk_d) begin
			idle <= 10'h000;
			line <= bit_clk_in ? left_in : right_in;
		end else if (idle < 10'h190) begin
			idle <= idle + 10'h001;
		end else begin
			// released: toggle so stale data never looks valid
			line <= ~line;
		end
	end
endmodule : arc_mic_model
`default_nettype wire

//--- verif/arc_converter_test.sv
// Purpose: self-checking bench for the rate converter with density port
// Assumes: plain register port, frame syncs and a mic model as far side
// Notes: rate window shortened to 4000 cycles to keep the run short
`timescale 1ns/100ps
`default_nettype none
module arc_converter_test;
	import arc_pkg::*;
	logic clk_in, reset_in, wr, rd, fs_in, fs_out, ml, mr, dd;
	logic bclk, dout, irq_i, irq_o;
	logic [7:0] addr;
	logic [31:0] wd, rdat;
	logic [23:0] sl, sr, oleft, oright;
	int err_count = 0;
	int samples_checked = 0;
	int n_i = 0;
	int n_o = 0;
	int bi, bo, k;
	arc_converter #(.MEAS_WINDOW_CYCLES(4000)) i_dut (
		.clk_in(clk_in), .reset_in(reset_in),
		.reg_addr_in(addr), .reg_wdata_in(wd),
		.reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdat),
		.serial_in_left_in(sl), .serial_in_right_in(sr),
		.serial_audio_frame_sync_in(fs_in),
		.serial_out_frame_sync_in(fs_out),
		.serial_out_left_out(oleft), .serial_out_right_out(oright),
		.density_bit_clock_out(bclk), .density_data_in(dd),
		.density_data_out(dout),
		.input_sample_irq_out(irq_i), .output_sample_irq_out(irq_o)
	);
	arc_mic_model i_mic (.clk_in(clk_in), .bit_clk_in(bclk),
		.left_in(ml), .right_in(mr), .data_out(dd));
	////////////////////////////////////////////////////////////////////////
	// clock; irq high cycles are counted, so a wide pulse counts twice
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		n_i += (irq_i === 1'b1);
		n_o += (irq_o === 1'b1);
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_n(input int got, input int lo, input int hi);
		samples_checked++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("mismatch at %0t: count %0d", $time, got);
		end
	endtask : chk_n
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask : wr_reg
	// read data stand only in the cycle after the strobe edge
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 chk(rdat, e);
	endtask : rd_chk
	task automatic pulse(input bit o);
		@(posedge clk_in);
		if (o) fs_out <= 1'b1;
		else fs_in <= 1'b1;
		@(posedge clk_in);
		fs_out <= 1'b0;
		fs_in <= 1'b0;
		repeat (2) @(posedge clk_in);
	endtask : pulse
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask : wait_cyc
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd_chk(OFS_CTRL, 32'h0);
		rd_chk(OFS_ROUTE, 32'h0);
		rd_chk(OFS_IN_RATE, 32'(RST_RATE));
		rd_chk(OFS_DCLK_DIV, 32'(RST_DCLK_HALF));
		rd_chk(8'h40, 32'h0);
		@(posedge clk_in);
		#1 chk(rdat, 32'h0);
		chk(32'(bclk), 32'h0);
	endtask : t_reset
	task automatic t_regpath;
		wr_reg(OFS_CTRL, 32'h3);
		wr_reg(OFS_ROUTE, 32'h8);
		wr_reg(OFS_IN_A, 32'hA5C3E1FF);
		wr_reg(OFS_IN_B, 32'h123456AB);
		bi = n_i;
		bo = n_o;
		pulse(1'b0);
		pulse(1'b1);
		chk_n(n_i - bi, 1, 1);
		chk_n(n_o - bo, 1, 1);
		rd_chk(OFS_OUT_A, 32'hA5C3E100);
		rd_chk(OFS_OUT_B, 32'h12345600);
		chk(32'(oleft), 32'h00A5C3E1);
		chk(32'(oright), 32'h00123456);
	endtask : t_regpath
	task automatic t_serial;
		wr_reg(OFS_ROUTE, 32'h9);
		sl <= 24'h7FFFFF;
		sr <= 24'h800001;
		pulse(1'b0);
		pulse(1'b1);
		chk(32'(oleft), 32'h007FFFFF);
		chk(32'(oright), 32'h00800001);
		rd_chk(OFS_OUT_B, 32'h80000100);
	endtask : t_serial
	task automatic t_rate;
		wr_reg(OFS_CTRL, 32'h0);
		wr_reg(OFS_IN_RATE, 32'd1000);
		rd_chk(OFS_IN_RATE, 32'd8000);
		wr_reg(OFS_IN_RATE, 32'd300000);
		rd_chk(OFS_IN_RATE, 32'd192000);
		bi = n_i;
		wait_cyc(4000);
		chk_n(n_i - bi, 19, 20);
		wr_reg(OFS_OUT_RATE, 32'd20000);
		rd_chk(OFS_CTRL, 32'h100);
		wr_reg(OFS_OUT_RATE, 32'd16000);
		rd_chk(OFS_CTRL, 32'h0);
		wr_reg(OFS_CTRL, 32'h1);
		// one event every 400 cycles gives ten per window
		repeat (30) begin
			pulse(1'b0);
			wait_cyc(396);
		end
		rd_chk(OFS_IN_RATE, 32'd10);
	endtask : t_rate
	task automatic t_dclk;
		wr_reg(OFS_DCLK_DIV, 32'd1);
		rd_chk(OFS_DCLK_DIV, 32'd5);
		wr_reg(OFS_DCLK_DIV, 32'd400);
		rd_chk(OFS_DCLK_DIV, 32'd320);
		wr_reg(OFS_DCLK_DIV, 32'd5);
		wr_reg(OFS_CTRL, 32'h4);
		k = 0;
		while (bclk !== 1'b1 && k < 50) begin
			@(posedge clk_in);
			#1 k++;
		end
		k = 0;
		while (bclk === 1'b1 && k < 50) begin
			@(posedge clk_in);
			#1 k++;
		end
		chk_n(k, 5, 5);
		wr_reg(OFS_CTRL, 32'h0);
		wait_cyc(2);
		k = 0;
		repeat (400) begin
			@(posedge clk_in);
			#1 k += (bclk !== 1'b0);
		end
		chk_n(k, 0, 0);
	endtask : t_dclk
	task automatic t_dens;
		wr_reg(OFS_ROUTE, 32'hA);
		wr_reg(OFS_CTRL, 32'h6);
		bi = n_i;
		wait_cyc(6400);
		chk_n(n_i - bi, 9, 10);
		pulse(1'b1);
		chk(32'(oleft), 32'h00400000);
		chk(32'(oright), 32'h00C00000);
		chk(32'(dout), 32'h0);
		wr_reg(OFS_CTRL, 32'h2);
		wait_cyc(3);
		bi = n_i;
		wait_cyc(2000);
		chk_n(n_i - bi, 0, 0);
	endtask : t_dens
	// full-scale pair: left slot settles to ones, right slot to zeros
	task automatic t_dens_out;
		wr_reg(OFS_ROUTE, 32'h5);
		wr_reg(OFS_CTRL, 32'h5);
		pulse(1'b0);
		wait_cyc(1500);
		rd_chk(OFS_OUT_A, 32'h7FFFFF00);
		chk(32'(oleft), 32'h0);
		k = 0;
		repeat (200) begin
			@(posedge clk_in);
			#1 k += (dout !== ~bclk);
		end
		chk_n(k, 0, 0);
		wr_reg(OFS_CTRL, 32'hD);
		wait_cyc(20);
		k = 0;
		repeat (200) begin
			@(posedge clk_in);
			#1 k += (dout !== bclk);
		end
		chk_n(k, 0, 0);
		wr_reg(OFS_CTRL, 32'h0);
	endtask : t_dens_out
	////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test
	// main sequence; all inputs defined at time zero
	initial begin
		reset_in = 1'b1;
		{wr, rd, fs_in, fs_out, mr} = 5'h00;
		ml = 1'b1;
		addr = 8'h00;
		wd = 32'h0;
		sl = 24'h0;
		sr = 24'h0;
		wait_cyc(10);
		reset_in <= 1'b0;
		@(posedge clk_in);
		t_reset;
		t_regpath;
		t_serial;
		t_rate;
		t_dclk;
		t_dens;
		t_dens_out;
		stop_test;
	end
	// watchdog well beyond the roughly 27000 cycles of the tests
	initial begin
		#1500000;
		err_count++;
		stop_test;
	end
endmodule : arc_converter_test
`default_nettype wire
